// file: design/agtm_addr_unit.sv
`timescale 1ns/1ps
// =====================================================================
// One address unit: eight index pointers and eight step registers
module agtm_addr_unit import agtm_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire agtm_ureq_t  req_in,
  input  wire logic        wr_en_in,
  input  wire logic        wr_step_in,
  input  wire logic [2:0]  wr_sel_in,
  input  wire logic [31:0] wr_data_in,
  output logic [31:0]      addr_out
);

  logic [31:0] idx_q [NREG];
  logic [31:0] stp_q [NREG];

  // Offset selection and adder
  wire [31:0] cur_idx  = idx_q[req_in.idx];
  wire [31:0] offset   = req_in.use_imm ? agtm_sext(req_in.imm, req_in.imm_sel)
                                        : stp_q[req_in.stp];
  wire [31:0] sum      = cur_idx + offset;
  wire        upd_post = (req_in.uop == UOP_XFER) && !req_in.pre;
  wire        upd_mod  = (req_in.uop == UOP_MODIFY);
  wire        upd_rev  = (req_in.uop == UOP_MIRROR);

  // Pre-modify shows the sum, post-modify the pointer as it stands
  assign addr_out = req_in.pre ? sum : cur_idx;

  // Register writes first, so an update in the same cycle takes over
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NREG; i++) begin
        idx_q[i] <= IDX_RST;
        stp_q[i] <= STP_RST;
      end
    end else begin
      if (wr_en_in && wr_step_in) begin
        stp_q[wr_sel_in] <= wr_data_in;
      end
      if (wr_en_in && !wr_step_in) begin
        idx_q[wr_sel_in] <= wr_data_in;
      end
      if (upd_post) begin
        idx_q[req_in.idx] <= sum;
      end
      if (upd_mod) begin
        idx_q[req_in.dst] <= sum;
      end
      if (upd_rev) begin
        idx_q[req_in.dst] <= agtm_mirror(sum);
      end
    end
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  wire no_iwr = !(wr_en_in && !wr_step_in);

  AST_PRE_KEEP: assert property (req_in.uop == UOP_XFER && req_in.pre && no_iwr
    |=> idx_q[$past(req_in.idx)] == $past(cur_idx))
    else $error("pre-modify changed its index pointer");
  AST_POST_UPD: assert property (upd_post && no_iwr
    |-> addr_out == cur_idx ##1 idx_q[$past(req_in.idx)] == $past(sum))
    else $error("post-modify address or write-back wrong");
  AST_MOD_DST: assert property (upd_mod && no_iwr
    |=> idx_q[$past(req_in.dst)] == $past(sum))
    else $error("modify result not written to destination pointer");
  AST_REV_DST: assert property (upd_rev && no_iwr
    |=> idx_q[$past(req_in.dst)] == agtm_mirror($past(sum)))
    else $error("bit-reversed result not written to destination pointer");
  AST_IMM6: assert property (req_in.use_imm && req_in.imm_sel == IMM_6
    |-> offset == {{26{req_in.imm[5]}}, req_in.imm[5:0]})
    else $error("six-bit immediate offset not sign-extended");
  AST_IMM7: assert property (req_in.use_imm && req_in.imm_sel == IMM_7 && req_in.pre
    |-> addr_out == cur_idx + {{25{req_in.imm[6]}}, req_in.imm[6:0]})
    else $error("seven-bit pre-modify address wrong");

endmodule

// file: design/agtm_core.sv
`timescale 1ns/1ps
module agtm_core import agtm_pkg::*; (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire agtm_cmd_t         cmd_in,
  input  wire agtm_regwr_t       reg_wr_in,
  input  wire logic [NBLK-1:0]   block_width_select_in,
  input  wire logic              second_element_enable_in,
  input  wire logic              fetch_req_in,
  input  wire logic [31:0]       fetch_addr_in,
  input  wire logic [47:0]       dm_rdata_in,
  input  wire logic [47:0]       pm_rdata_in,
  output agtm_bus_t              dm_bus_out,
  output agtm_bus_t              pm_bus_out,
  output logic                   fetch_grant_out,
  output logic                   dm_load_valid_out,
  output logic [47:0]            dm_load_data_out,
  output logic                   pm_load_valid_out,
  output logic [47:0]            pm_load_data_out,
  output logic                   pm_load_fetch_out
);

  // =====================================================================
  // Helpers

  // Width of one access: forcing wins inside the normal-word window only
  function automatic agtm_wid_t pick_width(input logic [31:0] a, input logic lw,
                                           input agtm_src_t s, input logic [NBLK-1:0] bws);
    logic nw;
    logic [BLK_W-1:0] blk;
    nw  = (a >= NW_BASE) && (a <= NW_TOP);
    blk = a[BLK_LSB +: BLK_W];
    if (nw && lw) pick_width = WID_LONG;
    else if (s == SRC_XCHG) pick_width = WID_48;
    else if (nw && bws[blk] && s == SRC_DATA) pick_width = WID_40;
    else pick_width = WID_32;
  endfunction

  // Place register-side data into a memory word
  function automatic logic [47:0] pack_data(input logic [47:0] d, input agtm_src_t s,
                                            input agtm_wid_t w);
    case (w)
      WID_40:  pack_data = {d[39:0], 8'h00};
      WID_48:  pack_data = d;
      default: pack_data = (s == SRC_IMM16) ? {32'h0000_0000, d[15:0]}
                                            : {16'h0000, d[31:0]};
    endcase
  endfunction

  // Take a memory word back to the register side
  function automatic logic [47:0] unpack_data(input logic [47:0] d, input agtm_wid_t w);
    case (w)
      WID_40:  unpack_data = {8'h00, d[47:8]};
      WID_48:  unpack_data = d;
      default: unpack_data = {16'h0000, d[31:0]};
    endcase
  endfunction

  // =====================================================================
  // Address units and write steering

  wire [31:0] u1_addr;
  wire [31:0] u2_addr;
  wire        cmd_ok  = cmd_in.valid;
  wire        wr_u1   = reg_wr_in.valid && !reg_wr_in.unit;
  wire        wr_u2   = reg_wr_in.valid && reg_wr_in.unit;

  // Operations only reach a unit while the command is valid
  agtm_ureq_t u1_req;
  agtm_ureq_t u2_req;
  always_comb begin
    u1_req = cmd_in.u1;
    u2_req = cmd_in.u2;
    if (!cmd_ok) begin
      u1_req.uop = UOP_NONE;
      u2_req.uop = UOP_NONE;
    end
  end

  agtm_addr_unit u_first (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .req_in     (u1_req),
    .wr_en_in   (wr_u1),
    .wr_step_in (reg_wr_in.step),
    .wr_sel_in  (reg_wr_in.sel),
    .wr_data_in (reg_wr_in.data),
    .addr_out   (u1_addr)
  );

  agtm_addr_unit u_second (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .req_in     (u2_req),
    .wr_en_in   (wr_u2),
    .wr_step_in (reg_wr_in.step),
    .wr_sel_in  (reg_wr_in.sel),
    .wr_data_in (reg_wr_in.data),
    .addr_out   (u2_addr)
  );

  // =====================================================================
  // Bus decode

  // First unit always owns the data bus, second the program bus ahead of fetch, so a dual move fits one cycle
  wire        dm_go   = (u1_req.uop == UOP_XFER);
  wire        pm_go   = (u2_req.uop == UOP_XFER);
  wire        fet_go  = fetch_req_in && !pm_go;
  wire agtm_wid_t dm_w = pick_width(u1_addr, cmd_in.long_word_force, cmd_in.dm.src,
                                    block_width_select_in);
  wire agtm_wid_t pm_w = pick_width(u2_addr, cmd_in.long_word_force, cmd_in.pm.src,
                                    block_width_select_in);

  // The enable of the second element has no say in the width; it is kept for
  // callers that mirror it, and forcing overrides it by construction
  wire unused_pe = second_element_enable_in;

  // =====================================================================
  // Bus outputs, one cycle after the command
  agtm_bus_t dm_d;
  agtm_bus_t pm_d;
  always_comb begin
    dm_d.rd    = dm_go && !cmd_in.dm.write;
    dm_d.wr    = dm_go && cmd_in.dm.write;
    dm_d.addr  = dm_go ? u1_addr : 32'h0000_0000;
    dm_d.width = dm_go ? dm_w : WID_32;
    dm_d.wdata = dm_d.wr ? pack_data(cmd_in.dm.data, cmd_in.dm.src, dm_w) : 48'h0;
    pm_d.rd    = (pm_go && !cmd_in.pm.write) || fet_go;
    pm_d.wr    = pm_go && cmd_in.pm.write;
    pm_d.addr  = pm_go ? u2_addr : (fet_go ? fetch_addr_in : 32'h0000_0000);
    pm_d.width = pm_go ? pm_w : WID_48;
    pm_d.wdata = pm_d.wr ? pack_data(cmd_in.pm.data, cmd_in.pm.src, pm_w) : 48'h0;
  end

  // Registered bus strobes; the load stage remembers width and fetch tag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dm_bus_out      <= '{rd: 1'b0, wr: 1'b0, addr: 32'h0, wdata: 48'h0, width: WID_32};
      pm_bus_out      <= '{rd: 1'b0, wr: 1'b0, addr: 32'h0, wdata: 48'h0, width: WID_48};
      fetch_grant_out <= 1'b0;
    end else begin
      dm_bus_out      <= dm_d;
      pm_bus_out      <= pm_d;
      fetch_grant_out <= fet_go;
    end
  end

  // =====================================================================
  // Load return: memory answers the cycle after the strobe, so the strobe,
  // its width and fetch tag wait one stage; taking read data any earlier
  // would latch a stale word
  logic      dm_rd_q;
  logic      pm_rd_q;
  logic      fetch_q;
  agtm_wid_t dm_wid_q;
  agtm_wid_t pm_wid_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dm_rd_q  <= 1'b0;
      pm_rd_q  <= 1'b0;
      fetch_q  <= 1'b0;
      dm_wid_q <= WID_32;
      pm_wid_q <= WID_48;
    end else begin
      dm_rd_q  <= dm_bus_out.rd;
      pm_rd_q  <= pm_bus_out.rd;
      fetch_q  <= fetch_grant_out;
      dm_wid_q <= dm_bus_out.width;
      pm_wid_q <= pm_bus_out.width;
    end
  end

  // Read data is taken in the cycle in which memory drives it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dm_load_valid_out <= 1'b0;
      dm_load_data_out  <= 48'h0;
      pm_load_valid_out <= 1'b0;
      pm_load_data_out  <= 48'h0;
      pm_load_fetch_out <= 1'b0;
    end else begin
      dm_load_valid_out <= dm_rd_q;
      dm_load_data_out  <= dm_rd_q ? unpack_data(dm_rdata_in, dm_wid_q) : 48'h0;
      pm_load_valid_out <= pm_rd_q;
      pm_load_data_out  <= pm_rd_q ? unpack_data(pm_rdata_in, pm_wid_q) : 48'h0;
      pm_load_fetch_out <= fetch_q;
    end
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_DUAL: assert property (dm_go && pm_go
    |=> (dm_bus_out.rd || dm_bus_out.wr) && (pm_bus_out.rd || pm_bus_out.wr))
    else $error("dual transfer did not strobe both buses");
  AST_DM_ADDR: assert property (dm_go |=> dm_bus_out.addr == $past(u1_addr))
    else $error("data bus address not from the first unit");
  AST_PM_ADDR: assert property (pm_go |=> pm_bus_out.addr == $past(u2_addr))
    else $error("program bus address not from the second unit");
  AST_W40: assert property (dm_go && !cmd_in.long_word_force && cmd_in.dm.src == SRC_DATA
    && u1_addr >= NW_BASE && u1_addr <= NW_TOP
    && block_width_select_in[u1_addr[BLK_LSB +: BLK_W]] |=> dm_bus_out.width == WID_40)
    else $error("normal-word access not widened to 40 bits");
  AST_ZFILL: assert property (dm_bus_out.wr && dm_bus_out.width == WID_40
    |-> dm_bus_out.wdata[7:0] == 8'h00)
    else $error("40-bit store low byte not zero");
  AST_TRUNC: assert property (dm_bus_out.rd && dm_bus_out.width == WID_40
    ##1 1'b1 |=> dm_load_data_out == {8'h00, $past(dm_rdata_in[47:8])})
    else $error("40-bit load not truncated");
  AST_FETCH48: assert property (fetch_grant_out |-> pm_bus_out.rd && pm_bus_out.width == WID_48)
    else $error("fetch not a 48-bit read");
  AST_XCHG48: assert property (pm_go && cmd_in.pm.src == SRC_XCHG && !cmd_in.long_word_force
    |=> pm_bus_out.width == WID_48)
    else $error("exchange register move not 48 bits");
  AST_FORCE: assert property (dm_go && cmd_in.long_word_force
    |=> dm_bus_out.width == ((dm_bus_out.addr >= NW_BASE && dm_bus_out.addr <= NW_TOP)
        ? WID_LONG : $past(dm_w)))
    else $error("long-word forcing misapplied");

  COV_DUAL: cover property (dm_go && pm_go && cmd_in.dm.write != cmd_in.pm.write);
  COV_W40_LOAD: cover property (dm_bus_out.rd && dm_bus_out.width == WID_40 ##2 dm_load_valid_out);
  COV_FETCH: cover property (fetch_req_in && !pm_go ##3 pm_load_fetch_out);
  COV_MIRROR: cover property (u2_req.uop == UOP_MIRROR);

endmodule

// file: design/agtm_pkg.sv
// =====================================================================
// Shared types and constants for the address generator
package agtm_pkg;

  // Widths of addresses, data registers and memory words
  localparam int AW = 32;
  localparam int DW = 40;
  localparam int MW = 48;
  localparam int NREG = 8;

  // Normal-word address window and memory block field inside it
  localparam logic [31:0] NW_BASE = 32'h0009_0000;
  localparam logic [31:0] NW_TOP  = 32'h0009_ffff;
  localparam int          BLK_LSB = 14;
  localparam int          BLK_W   = 2;
  localparam int          NBLK    = 4;

  // Reset values
  localparam logic [31:0] IDX_RST = 32'h0000_0000;
  localparam logic [31:0] STP_RST = 32'h0000_0000;

  // Cycles from command to bus strobe, and from strobe to load result
  localparam int CMD_TO_BUS = 1;
  localparam int BUS_TO_LOAD = 2;

  // Per-unit operation
  typedef enum logic [3:0] {
    UOP_NONE   = 4'h1,
    UOP_XFER   = 4'h2,
    UOP_MODIFY = 4'h4,
    UOP_MIRROR = 4'h8
  } agtm_uop_t;

  // Immediate offset size
  typedef enum logic [2:0] {
    IMM_32 = 3'h1,
    IMM_7  = 3'h2,
    IMM_6  = 3'h4
  } agtm_imm_t;

  // Store data source
  typedef enum logic [4:0] {
    SRC_DATA  = 5'h01,
    SRC_UREG  = 5'h02,
    SRC_XCHG  = 5'h04,
    SRC_IMM32 = 5'h08,
    SRC_IMM16 = 5'h10
  } agtm_src_t;

  // Memory access width
  typedef enum logic [3:0] {
    WID_32   = 4'h1,
    WID_40   = 4'h2,
    WID_48   = 4'h4,
    WID_LONG = 4'h8
  } agtm_wid_t;

  typedef struct packed {
    agtm_uop_t   uop;
    logic        pre;
    logic        use_imm;
    agtm_imm_t   imm_sel;
    logic [2:0]  idx;
    logic [2:0]  stp;
    logic [2:0]  dst;
    logic [31:0] imm;
  } agtm_ureq_t;

  typedef struct packed {
    logic        write;
    agtm_src_t   src;
    logic [47:0] data;
  } agtm_side_t;

  typedef struct packed {
    logic        valid;
    logic        long_word_force;
    agtm_ureq_t  u1;
    agtm_ureq_t  u2;
    agtm_side_t  dm;
    agtm_side_t  pm;
  } agtm_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        unit;
    logic        step;
    logic [2:0]  sel;
    logic [31:0] data;
  } agtm_regwr_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [47:0] wdata;
    agtm_wid_t   width;
  } agtm_bus_t;

  // Sign-extend an immediate offset of the selected size
  function automatic logic [31:0] agtm_sext(input logic [31:0] v, input agtm_imm_t s);
    case (s)
      IMM_6:   agtm_sext = {{26{v[5]}}, v[5:0]};
      IMM_7:   agtm_sext = {{25{v[6]}}, v[6:0]};
      default: agtm_sext = v;
    endcase
  endfunction

  // Reverse all bits of an address
  function automatic logic [31:0] agtm_mirror(input logic [31:0] v);
    for (int i = 0; i < AW; i++) begin
      agtm_mirror[i] = v[AW-1-i];
    end
  endfunction

endpackage

// file: tb/agtm_core_bench.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the address generator core
module agtm_core_bench import agtm_pkg::*; ;
  logic            clk_in = 1'b0;
  logic            rst_in = 1'b1;
  agtm_cmd_t       cmd_in;
  agtm_cmd_t       ic;
  agtm_regwr_t     reg_wr_in;
  logic [NBLK-1:0] bws;
  logic            see;
  logic            fetch_req;
  logic [31:0]     fetch_addr;
  logic [47:0]     dm_rdata;
  logic [47:0]     pm_rdata;
  agtm_bus_t       dm_bus;
  agtm_bus_t       pm_bus;
  logic            fetch_grant;
  logic            dm_lv;
  logic            pm_lv;
  logic            pm_lf;
  logic [47:0]     dm_ld;
  logic [47:0]     pm_ld;
  agtm_ureq_t      nu;
  agtm_side_t      ns;
  int              miscompares = 0;
  int              n_compared = 0;

  // =====================================================================
  // Clock, design and memory
  always #50 clk_in = ~clk_in;

  agtm_core u_agtm_core (
    .clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd_in), .reg_wr_in(reg_wr_in),
    .block_width_select_in(bws), .second_element_enable_in(see),
    .fetch_req_in(fetch_req), .fetch_addr_in(fetch_addr),
    .dm_rdata_in(dm_rdata), .pm_rdata_in(pm_rdata),
    .dm_bus_out(dm_bus), .pm_bus_out(pm_bus), .fetch_grant_out(fetch_grant),
    .dm_load_valid_out(dm_lv), .dm_load_data_out(dm_ld),
    .pm_load_valid_out(pm_lv), .pm_load_data_out(pm_ld), .pm_load_fetch_out(pm_lf)
  );

  agtm_mem_model u_agtm_mem_model (
    .clk_in(clk_in), .dm_bus_in(dm_bus), .pm_bus_in(pm_bus),
    .dm_rdata_out(dm_rdata), .pm_rdata_out(pm_rdata)
  );

  // =====================================================================
  // Builders and compare tasks
  function automatic agtm_ureq_t ur(input agtm_uop_t op, input logic pre, input logic ui,
                                    input agtm_imm_t is, input logic [2:0] idx,
                                    input logic [2:0] dst, input logic [31:0] imm);
    ur = '{op, pre, ui, is, idx, 3'h0, dst, imm};
  endfunction

  function automatic agtm_side_t sd(input logic w, input agtm_src_t s, input logic [47:0] d);
    sd = '{w, s, d};
  endfunction

  function automatic agtm_cmd_t cm(input logic lw, input agtm_ureq_t a, input agtm_ureq_t b,
                                   input agtm_side_t x, input agtm_side_t y);
    cm = '{1'b1, lw, a, b, x, y};
  endfunction

  function automatic agtm_bus_t bus(input logic rd, input logic wr, input logic [31:0] a,
                                    input logic [47:0] d, input agtm_wid_t w);
    bus = '{rd, wr, a, d, w};
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      rev32[i] = v[31-i];
    end
  endfunction

  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write data is a don't-care on reads, so it is not judged there
  task automatic chk_bus(input agtm_bus_t got, input agtm_bus_t exp);
    n_compared++;
    if (exp.rd === 1'b1) begin
      exp.wdata = got.wdata;
    end
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // =====================================================================
  // Drivers: one command per call, bus outputs sampled mid-cycle after it
  task automatic wreg(input logic u, input logic s, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= '{1'b1, u, s, 3'h0, d};
    @(posedge clk_in);
    reg_wr_in <= '0;
  endtask

  task automatic send(input agtm_cmd_t c);
    @(posedge clk_in);
    cmd_in <= c;
    @(posedge clk_in);
    cmd_in <= ic;
    @(negedge clk_in);
  endtask

  task automatic wait_load();
    repeat (2) @(negedge clk_in);
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_reset();
    chk_bus(dm_bus, bus(1'b0, 1'b0, 32'h0, 48'h0, WID_32));
    chk_bus(pm_bus, bus(1'b0, 1'b0, 32'h0, 48'h0, WID_48));
  endtask

  // Dual transfer: 40-bit load on the data bus, store on the program bus
  task automatic t_dual();
    send(cm(1'b0, ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0), ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0),
            sd(1'b0, SRC_DATA, 0), sd(1'b1, SRC_DATA, 48'h0011_2233_4455)));
    chk_bus(dm_bus, bus(1'b1, 1'b0, 32'h0009_0010, 48'h0, WID_40));
    chk_bus(pm_bus, bus(1'b0, 1'b1, 32'h0000_1000, 48'h0000_2233_4455, WID_32));
    wait_load();
    chk_val({dm_lv, pm_lv}, 48'h2);
    chk_val(dm_ld, 48'h005a_5a00_0900);
    send(cm(1'b0, ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0), ur(UOP_XFER, 0, 1, IMM_6, 0, 0, 32'h3f),
            sd(1'b0, SRC_UREG, 0), sd(1'b0, SRC_UREG, 0)));
    chk_bus(dm_bus, bus(1'b1, 1'b0, 32'h0009_0014, 48'h0, WID_32));
    chk_bus(pm_bus, bus(1'b1, 1'b0, 32'h0000_1008, 48'h0, WID_32));
    wait_load();
    chk_val(pm_ld, 48'h0000_0000_1008);
  endtask

  // Pre-modify with forced long word, exchange register store, then immediates
  task automatic t_pre_imm();
    send(cm(1'b0, ur(UOP_XFER, 1, 1, IMM_7, 0, 0, 0), nu, sd(1'b1, SRC_DATA, 48'h0011_2233_4455),
            ns));
    chk_bus(dm_bus, bus(1'b0, 1'b1, 32'h0009_0018, 48'h1122_3344_5500, WID_40));
    send(cm(1'b1, ur(UOP_XFER, 1, 1, IMM_7, 0, 0, 32'h7c), ur(UOP_XFER, 1, 1, IMM_32, 0, 0, 32'h100),
            sd(1'b1, SRC_UREG, 48'hcafe_f00d), sd(1'b1, SRC_XCHG, 48'hfedc_ba98_7654)));
    chk_bus(dm_bus, bus(1'b0, 1'b1, 32'h0009_0014, 48'hcafe_f00d, WID_LONG));
    chk_bus(pm_bus, bus(1'b0, 1'b1, 32'h0000_1107, 48'hfedc_ba98_7654, WID_48));
    send(cm(1'b0, ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0), ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0),
            sd(1'b1, SRC_IMM32, 48'h1234_5678), sd(1'b1, SRC_IMM16, 48'hbeef)));
    chk_bus(dm_bus, bus(1'b0, 1'b1, 32'h0009_0018, 48'h1234_5678, WID_32));
    chk_bus(pm_bus, bus(1'b0, 1'b1, 32'h0000_1007, 48'h0000_beef, WID_32));
  endtask

  // Modify into another pointer and bit-reverse in place; no bus activity
  task automatic t_modify();
    send(cm(1'b0, ur(UOP_MODIFY, 0, 1, IMM_32, 0, 1, 32'h20), ur(UOP_MIRROR, 0, 0, IMM_32, 0, 0, 0),
            ns, ns));
    chk_val({dm_bus.rd, dm_bus.wr, pm_bus.rd, pm_bus.wr}, 48'h0);
    send(cm(1'b0, ur(UOP_XFER, 0, 0, IMM_32, 1, 1, 0), ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0),
            sd(1'b0, SRC_UREG, 0), sd(1'b0, SRC_UREG, 0)));
    chk_val(dm_bus.addr, 48'h0009_003c);
    chk_val(pm_bus.addr, rev32(32'h0000_1017));
    send(cm(1'b0, ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0), nu, sd(1'b0, SRC_UREG, 0), ns));
    chk_val(dm_bus.addr, 48'h0009_001c);
    chk_val({dm_bus.rd, pm_bus.rd, pm_bus.wr}, 48'h4);
  endtask

  // Fetch loses to a second-unit transfer, then wins on an idle cycle
  task automatic t_fetch();
    @(posedge clk_in);
    fetch_req <= 1'b1;
    fetch_addr <= 32'h0009_0200;
    cmd_in <= cm(1'b0, nu, ur(UOP_XFER, 0, 0, IMM_32, 0, 0, 0), ns, sd(1'b0, SRC_UREG, 0));
    @(posedge clk_in);
    cmd_in <= ic;
    @(negedge clk_in);
    chk_val({fetch_grant, pm_bus.rd}, 48'h1);
    chk_val(pm_bus.addr, rev32(32'h0000_1017) + 32'h8);
    @(posedge clk_in);
    fetch_req <= 1'b0;
    @(negedge clk_in);
    chk_val(fetch_grant, 48'h1);
    chk_bus(pm_bus, bus(1'b1, 1'b0, 32'h0009_0200, 48'h0, WID_48));
    wait_load();
    chk_val({pm_lv, pm_lf}, 48'h3);
    chk_val(pm_ld, 48'ha5a5_0009_0200);
  endtask

  // =====================================================================
  // Verdict and end of run
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    close_out();
  end

  // Main sequence; block 0 runs 40-bit, element enable set to show it is ignored
  initial begin
    nu = ur(UOP_NONE, 0, 0, IMM_32, 0, 0, 0);
    ns = sd(1'b0, SRC_DATA, 48'h0);
    ic = '{1'b0, 1'b0, nu, nu, ns, ns};
    cmd_in = ic;
    reg_wr_in = '0;
    bws = 4'h1;
    see = 1'b1;
    fetch_req = 1'b0;
    fetch_addr = 32'h0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    t_reset();
    wreg(1'b0, 1'b0, 32'h0009_0010);
    wreg(1'b0, 1'b1, 32'h0000_0004);
    wreg(1'b1, 1'b0, 32'h0000_1000);
    wreg(1'b1, 1'b1, 32'h0000_0008);
    t_dual();
    t_pre_imm();
    t_modify();
    t_fetch();
    close_out();
  end
endmodule

// file: tb/agtm_mem_model.sv
`timescale 1ns/1ps
// =====================================================================
// Internal memory blocks behind the data and program buses
module agtm_mem_model import agtm_pkg::*; (
  input  wire logic      clk_in,
  input  wire agtm_bus_t dm_bus_in,
  input  wire agtm_bus_t pm_bus_in,
  output logic [47:0]    dm_rdata_out,
  output logic [47:0]    pm_rdata_out
);
  // Reads answer one cycle after the strobe with a tagged copy of the address;
  // idle cycles invert the bus so a word left from the cycle before cannot pass for a fresh word
  always @(posedge clk_in) begin
    if (dm_bus_in.rd) begin
      dm_rdata_out <= {16'h5a5a, dm_bus_in.addr};
    end else begin
      dm_rdata_out <= ~dm_rdata_out;
    end
    if (pm_bus_in.rd) begin
      pm_rdata_out <= {16'ha5a5, pm_bus_in.addr};
    end else begin
      pm_rdata_out <= ~pm_rdata_out;
    end
  end

  // Known start so the inversion does not stay unknown forever
  initial begin
    dm_rdata_out = 48'h0000_0000_0000;
    pm_rdata_out = 48'h0000_0000_0000;
  end
endmodule
